// File: memory_board_decoder.sv
// Operation
// - Each bank maps to one of 64 pages
// - Each bank keeps its own page selection
// - Page base is page number times 256K
// - Four sites: two banks, two groups each
// - Range from size and offset, up or down
// - At most four types, two per bank
// - Byte-only or mixed byte/word transfer mode
// - Mixed byte/word mode after reset
// - Local bus offers normal or optimized protocol
// - Serve system bus or local bus, selected
`timescale 1ns/1ps
module memory_board_decoder (
  // Clock and reset
  input  wire logic                             clk_i,
  input  wire logic                             resetn_i,
  // Register port
  input  wire logic [3:0]                       reg_addr_i,
  input  wire logic [31:0]                      reg_wdata_i,
  input  wire logic                             reg_wr_i,
  input  wire logic                             reg_rd_i,
  output logic      [31:0]                      reg_rdata_o,
  // System bus request
  input  wire logic                             sys_req_i,
  input  wire logic [decoder_pkg::ADDR_W-1:0]   sys_addr_i,
  input  wire logic                             sys_hi_en_i,
  // Local bus request
  input  wire logic                             loc_req_i,
  input  wire logic [decoder_pkg::ADDR_W-1:0]   loc_addr_i,
  input  wire logic                             loc_hi_en_i,
  // Decode results
  output logic      [decoder_pkg::BANKS-1:0]    bank_sel_o,
  output logic      [3:0]                       group_sel_o,
  output logic      [decoder_pkg::TYPE_W-1:0]   sel_type_o,
  output logic                                  lo_byte_o,
  output logic                                  hi_byte_o,
  output logic      [decoder_pkg::ADDR_W-2:0]   dev_addr_o,
  output logic                                  opt_mode_o,
  output logic                                  local_mode_o
);
  import decoder_pkg::*;

  // Reset release and input synchronisers
  logic rst_q1;
  logic rst_n;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  logic [ADDR_W+1:0] sys_s1;
  logic [ADDR_W+1:0] sys_s2;
  logic [ADDR_W+1:0] loc_s1;
  logic [ADDR_W+1:0] loc_s2;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sys_s1 <= '0;
      sys_s2 <= '0;
      loc_s1 <= '0;
      loc_s2 <= '0;
    end else begin
      sys_s1 <= {sys_req_i, sys_hi_en_i, sys_addr_i};
      sys_s2 <= sys_s1;
      loc_s1 <= {loc_req_i, loc_hi_en_i, loc_addr_i};
      loc_s2 <= loc_s1;
    end
  end

  // Configuration registers
  logic              wide_mode;
  logic              local_mode;
  logic              opt_mode;
  logic [PAGE_W-1:0] page_q  [BANKS];
  logic [SIZE_W-1:0] size_q  [BANKS];
  logic              down_q  [BANKS];
  logic [OFFS_W-1:0] ofs_q   [BANKS];
  logic [TYPE_W-1:0] type_q  [BANKS*GROUPS];

  wire wr_ctrl  = reg_wr_i && (reg_addr_i == REG_CTRL);
  wire wr_map0  = reg_wr_i && (reg_addr_i == REG_BANK0_MAP);
  wire wr_map1  = reg_wr_i && (reg_addr_i == REG_BANK1_MAP);
  wire wr_ofs0  = reg_wr_i && (reg_addr_i == REG_BANK0_OFS);
  wire wr_ofs1  = reg_wr_i && (reg_addr_i == REG_BANK1_OFS);
  wire wr_types = reg_wr_i && (reg_addr_i == REG_TYPES);
  wire [BANKS-1:0] wr_map = {wr_map1, wr_map0};
  wire [BANKS-1:0] wr_ofs = {wr_ofs1, wr_ofs0};

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wide_mode  <= RST_WIDE;
      local_mode <= RST_LOCAL;
      opt_mode   <= RST_OPT;
    end else if (wr_ctrl) begin
      wide_mode  <= reg_wdata_i[CTRL_WIDE_BIT];
      local_mode <= reg_wdata_i[CTRL_LOCAL_BIT];
      opt_mode   <= reg_wdata_i[CTRL_OPT_BIT];
    end
  end

  // Per-bank page, size, direction and offset
  for (genvar b = 0; b < BANKS; b++) begin : g_bank_cfg
    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        page_q[b] <= RST_PAGE;
        size_q[b] <= RST_SIZE;
        down_q[b] <= 1'b0;
        ofs_q[b]  <= (b == 0) ? RST_OFS0 : RST_OFS1;
      end else begin
        if (wr_map[b]) begin
          page_q[b] <= reg_wdata_i[MAP_PAGE_LSB +: PAGE_W];
          size_q[b] <= reg_wdata_i[MAP_SIZE_LSB +: SIZE_W];
          down_q[b] <= reg_wdata_i[MAP_DOWN_BIT];
        end
        if (wr_ofs[b]) begin
          ofs_q[b] <= reg_wdata_i[OFFS_W-1:0];
        end
      end
    end
  end

  // Group device types; writes breaking the type limits are refused
  wire [TYPE_W-1:0] new_type [BANKS*GROUPS];
  for (genvar g = 0; g < BANKS*GROUPS; g++) begin : g_new_type
    assign new_type[g] = reg_wdata_i[g*TYPE_FIELD +: TYPE_W];
  end

  function automatic logic [2:0] distinct4(
    input logic [TYPE_W-1:0] t0, input logic [TYPE_W-1:0] t1,
    input logic [TYPE_W-1:0] t2, input logic [TYPE_W-1:0] t3);
    logic [2:0] n;
    n = 3'h1;
    if (t1 != t0) n = n + 3'h1;
    if ((t2 != t0) && (t2 != t1)) n = n + 3'h1;
    if ((t3 != t0) && (t3 != t1) && (t3 != t2)) n = n + 3'h1;
    return n;
  endfunction : distinct4

  wire legal_types = (distinct4(new_type[0], new_type[1], new_type[2],
                                new_type[3]) <= 3'(MAX_TYPES))
                     && (new_type[0] <= DEV_NVRAM)
                     && (new_type[1] <= DEV_NVRAM)
                     && (new_type[2] <= DEV_NVRAM)
                     && (new_type[3] <= DEV_NVRAM);
  logic type_reject;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      type_q[0]   <= RST_TYPE;
      type_q[1]   <= RST_TYPE;
      type_q[2]   <= RST_TYPE;
      type_q[3]   <= RST_TYPE;
      type_reject <= 1'b0;
    end else if (wr_types) begin
      type_reject <= !legal_types;
      if (legal_types) begin
        type_q[0] <= new_type[0];
        type_q[1] <= new_type[1];
        type_q[2] <= new_type[2];
        type_q[3] <= new_type[3];
      end
    end
  end

  // Active bus selection
  wire              req     = local_mode ? loc_s2[ADDR_W+1]
                                         : sys_s2[ADDR_W+1];
  wire              hi_en   = local_mode ? loc_s2[ADDR_W] : sys_s2[ADDR_W];
  wire [ADDR_W-1:0] addr    = local_mode ? loc_s2[ADDR_W-1:0]
                                         : sys_s2[ADDR_W-1:0];

  // Bank windows
  bank_cfg_if win0 ();
  bank_cfg_if win1 ();
  assign win0.page = page_q[0];
  assign win0.size = size_q[0];
  assign win0.down = down_q[0];
  assign win0.ofs  = ofs_q[0];
  assign win0.addr = addr;
  assign win1.page = page_q[1];
  assign win1.size = size_q[1];
  assign win1.down = down_q[1];
  assign win1.ofs  = ofs_q[1];
  assign win1.addr = addr;
  bank_window u_win0 (.cfg(win0.dec));
  bank_window u_win1 (.cfg(win1.dec));

  // Bank 0 wins if both windows overlap
  wire hit0 = req && win0.hit;
  wire hit1 = req && win1.hit && !win0.hit;

  // Group within bank from the upper half of the bank span
  wire [OFFS_W-1:0] span0   = SIZE_BASE << size_q[0];
  wire [OFFS_W-1:0] span1   = SIZE_BASE << size_q[1];
  wire [OFFS_W-1:0] rel0    = addr[OFFS_W-1:0] - (down_q[0]
                      ? (OFFS_W'(0) - ofs_q[0] - span0) : ofs_q[0]);
  wire [OFFS_W-1:0] rel1    = addr[OFFS_W-1:0] - (down_q[1]
                      ? (OFFS_W'(0) - ofs_q[1] - span1) : ofs_q[1]);
  wire              grp_hi0 = |(rel0 & (span0 >> 1));
  wire              grp_hi1 = |(rel1 & (span1 >> 1));
  wire [1:0]        grp_idx = hit1 ? {1'b1, grp_hi1} : {1'b0, grp_hi0};
  wire              hit_any = hit0 || hit1;

  // Byte lanes: mixed mode uses A0 and high-enable, byte-only uses A0
  wire lo_next = hit_any && (wide_mode ? !addr[0] : !addr[0]);
  wire hi_next = hit_any && (wide_mode ? hi_en : addr[0]);

  cyc_state_e state;
  cyc_state_e next_state;
  always_comb begin
    case (state)
      ST_IDLE:   next_state = !req ? ST_IDLE
                              : (hit_any ? ST_ACTIVE : ST_REJECT);
      ST_ACTIVE: next_state = req ? ST_ACTIVE : ST_IDLE;
      ST_REJECT: next_state = req ? ST_REJECT : ST_IDLE;
      default:   next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state        <= ST_IDLE;
      bank_sel_o   <= '0;
      group_sel_o  <= '0;
      sel_type_o   <= '0;
      lo_byte_o    <= 1'b0;
      hi_byte_o    <= 1'b0;
      dev_addr_o   <= '0;
      opt_mode_o   <= 1'b0;
      local_mode_o <= 1'b0;
    end else begin
      state        <= next_state;
      bank_sel_o   <= {hit1, hit0};
      group_sel_o  <= hit_any ? (4'h1 << grp_idx) : 4'h0;
      sel_type_o   <= type_q[grp_idx];
      lo_byte_o    <= lo_next;
      hi_byte_o    <= hi_next;
      dev_addr_o   <= addr[ADDR_W-1:1];
      opt_mode_o   <= local_mode && opt_mode;
      local_mode_o <= local_mode;
    end
  end

  // Readback words, every field at its package position
  logic [31:0] ctrl_word;
  logic [31:0] map_word    [BANKS];
  logic [31:0] ofs_word    [BANKS];
  logic [31:0] types_word;
  logic [31:0] status_word;
  always_comb begin
    ctrl_word                 = 32'h0;
    ctrl_word[CTRL_WIDE_BIT]  = wide_mode;
    ctrl_word[CTRL_LOCAL_BIT] = local_mode;
    ctrl_word[CTRL_OPT_BIT]   = opt_mode;
    for (int b = 0; b < BANKS; b++) begin
      map_word[b]                         = 32'h0;
      map_word[b][MAP_PAGE_LSB +: PAGE_W] = page_q[b];
      map_word[b][MAP_SIZE_LSB +: SIZE_W] = size_q[b];
      map_word[b][MAP_DOWN_BIT]           = down_q[b];
      ofs_word[b]                         = 32'h0;
      ofs_word[b][OFFS_W-1:0]             = ofs_q[b];
    end
    types_word = 32'h0;
    for (int g = 0; g < BANKS*GROUPS; g++) begin
      types_word[g*TYPE_FIELD +: TYPE_W] = type_q[g];
    end
    // Status shows the cycle state, range overflows and a refused write
    status_word                                    = 32'h0;
    status_word[STAT_STATE_LSB +: $bits(cyc_state_e)] = state;
    status_word[STAT_OVF_LSB]                      = win0.ovf;
    status_word[STAT_OVF_LSB + 1]                  = win1.ovf;
    status_word[STAT_REJECT_BIT]                   = type_reject;
  end

  // Register read mux
  logic [31:0] rd_mux;
  always_comb begin
    case (reg_addr_i)
      REG_CTRL:      rd_mux = ctrl_word;
      REG_BANK0_MAP: rd_mux = map_word[0];
      REG_BANK1_MAP: rd_mux = map_word[1];
      REG_BANK0_OFS: rd_mux = ofs_word[0];
      REG_BANK1_OFS: rd_mux = ofs_word[1];
      REG_TYPES:     rd_mux = types_word;
      REG_STATUS:    rd_mux = status_word;
      default:       rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0;
    end
  end
endmodule : memory_board_decoder

// File: decoder_pkg.sv
package decoder_pkg;
  // Address geometry: 24-bit byte address, 64 pages of 256K bytes
  localparam int ADDR_W      = 24;
  localparam int PAGE_W      = 6;
  localparam int PAGE_COUNT  = 64;
  localparam int PAGE_SHIFT  = 18;
  localparam logic [23:0] PAGE_BYTES = 24'h040000;
  localparam int OFFS_W      = 18;
  localparam int SIZE_W      = 3;
  localparam int TYPE_W      = 3;
  localparam int BANKS       = 2;
  localparam int GROUPS      = 2;
  localparam int SITES       = 4;
  localparam int MAX_TYPES   = 4;
  localparam int TYPES_BANK  = 2;

  // Register offsets (index = word address)
  localparam logic [3:0] REG_CTRL      = 4'h0;
  localparam logic [3:0] REG_BANK0_MAP = 4'h1;
  localparam logic [3:0] REG_BANK1_MAP = 4'h2;
  localparam logic [3:0] REG_BANK0_OFS = 4'h3;
  localparam logic [3:0] REG_BANK1_OFS = 4'h4;
  localparam logic [3:0] REG_TYPES     = 4'h5;
  localparam logic [3:0] REG_STATUS    = 4'h6;

  // Control register fields
  localparam int CTRL_WIDE_BIT   = 0;
  localparam int CTRL_LOCAL_BIT  = 1;
  localparam int CTRL_OPT_BIT    = 2;
  // Bank map register fields
  localparam int MAP_PAGE_LSB    = 0;
  localparam int MAP_SIZE_LSB    = 8;
  localparam int MAP_DOWN_BIT    = 12;
  // Type register: one field per group, four bits apart
  localparam int TYPE_FIELD      = 4;
  // Status register fields
  localparam int STAT_STATE_LSB  = 0;
  localparam int STAT_OVF_LSB    = 3;
  localparam int STAT_REJECT_BIT = 5;

  // Reset values
  localparam logic       RST_WIDE   = 1'b1;
  localparam logic       RST_LOCAL  = 1'b0;
  localparam logic       RST_OPT    = 1'b0;
  localparam logic [5:0] RST_PAGE   = 6'h02;
  localparam logic [2:0] RST_SIZE   = 3'h0;
  localparam logic [17:0] RST_OFS0  = 18'h00000;
  localparam logic [17:0] RST_OFS1  = 18'h04000;
  localparam logic [2:0] RST_TYPE   = 3'h2;

  // Device size code k: bank spans 16K << k bytes (eight x8 devices)
  localparam logic [17:0] SIZE_BASE = 18'h04000;

  typedef enum logic [2:0] {
    DEV_EPROM     = 3'b000,
    DEV_EEPROM    = 3'b001,
    DEV_SRAM      = 3'b010,
    DEV_INTEG_RAM = 3'b011,
    DEV_NVRAM     = 3'b100
  } dev_type_e;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_REJECT = 2'b10
  } cyc_state_e;
endpackage : decoder_pkg

// File: bank_cfg_if.sv
`timescale 1ns/1ps
interface bank_cfg_if;
  import decoder_pkg::*;
  logic [PAGE_W-1:0] page;
  logic [SIZE_W-1:0] size;
  logic              down;
  logic [OFFS_W-1:0] ofs;
  logic [ADDR_W-1:0] addr;
  logic              hit;
  logic              ovf;
  modport ctrl (output page, output size, output down, output ofs,
                output addr, input hit, input ovf);
  modport dec  (input page, input size, input down, input ofs,
                input addr, output hit, output ovf);
endinterface : bank_cfg_if

// File: bank_window.sv
`timescale 1ns/1ps
module bank_window (
  // Configuration and address
  bank_cfg_if.dec cfg
);
  import decoder_pkg::*;
  wire [OFFS_W-1:0] span;
  wire [OFFS_W:0]   base_up;
  wire [OFFS_W:0]   base_dn;
  wire [OFFS_W:0]   base;
  wire [OFFS_W:0]   top;
  wire [OFFS_W-1:0] inpage;
  wire              page_ok;

  assign span    = SIZE_BASE << cfg.size;
  assign base_up = {1'b0, cfg.ofs};
  // Top-down: the range ends offset bytes below the page top
  assign base_dn = {1'b1, {OFFS_W{1'b0}}} - {1'b0, cfg.ofs}
                   - {1'b0, span};
  assign base    = cfg.down ? base_dn : base_up;
  assign top     = base + {1'b0, span};
  assign inpage  = cfg.addr[OFFS_W-1:0];
  // Page base = page number times 256K
  assign page_ok = (cfg.addr[ADDR_W-1:PAGE_SHIFT] == cfg.page);
  assign cfg.ovf = top[OFFS_W] & (top[OFFS_W-1:0] != '0);
  assign cfg.hit = page_ok && !cfg.ovf
                   && ({1'b0, inpage} >= base)
                   && ({1'b0, inpage} < top);
endmodule : bank_window

// File: decoder_asserts.sv
`timescale 1ns/1ps
module decoder_asserts (
  // Clock and reset
  input wire logic                           clk_i,
  input wire logic                           resetn_i,
  // Register port
  input wire logic [3:0]                     reg_addr_i,
  input wire logic                           reg_rd_i,
  input wire logic [31:0]                    reg_rdata_o,
  // Bus requests
  input wire logic                           sys_req_i,
  input wire logic [decoder_pkg::ADDR_W-1:0] sys_addr_i,
  input wire logic                           loc_req_i,
  // Decode results
  input wire logic [decoder_pkg::BANKS-1:0]  bank_sel_o,
  input wire logic [3:0]                     group_sel_o,
  input wire logic                           lo_byte_o,
  input wire logic                           hi_byte_o,
  input wire logic [decoder_pkg::ADDR_W-2:0] dev_addr_o,
  input wire logic                           opt_mode_o,
  input wire logic                           local_mode_o
);
  import decoder_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic [ADDR_W-1:0] sys_addr_q;
  always_ff @(posedge clk_i) sys_addr_q <= sys_addr_i;
  sequence sys_quiet; (!sys_req_i && !local_mode_o) [*4]; endsequence
  sequence loc_quiet; (!loc_req_i && local_mode_o) [*4]; endsequence
  sequence sys_held;
    (sys_req_i && $stable(sys_addr_i) && !local_mode_o) [*3];
  endsequence
  a_lanes_need_bank: assert property (
    bank_sel_o == 2'b00 |-> !lo_byte_o && !hi_byte_o)
    else $error("byte lane enabled without a bank hit");
  a_bank_one_hot: assert property (
    $onehot0(bank_sel_o)) else $error("both banks selected");
  a_group_in_bank: assert property (
    bank_sel_o == 2'b00 ||
    (bank_sel_o == 2'b01 && group_sel_o inside {4'h1, 4'h2}) ||
    (bank_sel_o == 2'b10 && group_sel_o inside {4'h4, 4'h8}))
    else $error("group select does not match bank");
  a_opt_needs_local: assert property (
    opt_mode_o |-> local_mode_o) else $error("optimized mode off local bus");
  a_sys_idle_nohit: assert property (
    sys_quiet |=> bank_sel_o == 2'b00) else $error("hit without request");
  a_loc_idle_nohit: assert property (
    loc_quiet |=> bank_sel_o == 2'b00) else $error("hit on unused bus");
  a_dev_addr_track: assert property (
    sys_held |=> bank_sel_o == 2'b00 ||
    dev_addr_o == sys_addr_q[ADDR_W-1:1])
    else $error("device address does not follow bus address");
  a_ctrl_mode_readback: assert property (
    reg_rd_i && reg_addr_i == REG_CTRL |=>
    reg_rdata_o[CTRL_LOCAL_BIT] == local_mode_o &&
    (reg_rdata_o[CTRL_OPT_BIT] && local_mode_o) == opt_mode_o)
    else $error("mode outputs disagree with control readback");
endmodule : decoder_asserts
bind memory_board_decoder decoder_asserts chk (
  .clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .sys_req_i(sys_req_i),
  .sys_addr_i(sys_addr_i), .loc_req_i(loc_req_i), .bank_sel_o(bank_sel_o),
  .group_sel_o(group_sel_o), .lo_byte_o(lo_byte_o), .hi_byte_o(hi_byte_o),
  .dev_addr_o(dev_addr_o), .opt_mode_o(opt_mode_o),
  .local_mode_o(local_mode_o));

// File: bus_master_model.sv
`timescale 1ns/1ps
module bus_master_model (
  // Clock
  input  wire logic                           clk_i,
  // System bus
  output logic                                sys_req_o,
  output logic [decoder_pkg::ADDR_W-1:0]      sys_addr_o,
  output logic                                sys_hi_en_o,
  // Local bus
  output logic                                loc_req_o,
  output logic [decoder_pkg::ADDR_W-1:0]      loc_addr_o,
  output logic                                loc_hi_en_o
);
  import decoder_pkg::*;
  initial begin
    sys_req_o = 1'b0;
    sys_addr_o = '0;
    sys_hi_en_o = 1'b0;
    loc_req_o = 1'b0;
    loc_addr_o = '0;
    loc_hi_en_o = 1'b0;
  end
  // One bus at a time; the idle bus shows inverted, stale lines
  task automatic drive(input logic l, input logic [ADDR_W-1:0] a,
                       input logic h);
    @(posedge clk_i);
    sys_req_o <= !l;
    loc_req_o <= l;
    sys_addr_o <= l ? ~sys_addr_o : a;
    loc_addr_o <= l ? a : ~loc_addr_o;
    sys_hi_en_o <= l ? ~sys_hi_en_o : h;
    loc_hi_en_o <= l ? h : ~loc_hi_en_o;
  endtask : drive
endmodule : bus_master_model

// File: tb_paged_memory_board_decoder.sv
`timescale 1ns/1ps
module tb_paged_memory_board_decoder;
  import decoder_pkg::*;
  logic              clk_i, resetn_i, reg_wr_i, reg_rd_i;
  logic [3:0]        reg_addr_i, group_sel_o;
  logic [31:0]       reg_wdata_i, reg_rdata_o, rd;
  logic              sys_req_i, sys_hi_en_i, loc_req_i, loc_hi_en_i;
  logic [ADDR_W-1:0] sys_addr_i, loc_addr_i;
  logic [1:0]        bank_sel_o;
  logic [2:0]        sel_type_o;
  logic              lo_byte_o, hi_byte_o, opt_mode_o, local_mode_o;
  logic [ADDR_W-2:0] dev_addr_o;
  int                err_total = 0;
  int                n_tests = 0;
  memory_board_decoder uut (.clk_i(clk_i), .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .sys_req_i(sys_req_i), .sys_addr_i(sys_addr_i),
    .sys_hi_en_i(sys_hi_en_i), .loc_req_i(loc_req_i),
    .loc_addr_i(loc_addr_i), .loc_hi_en_i(loc_hi_en_i),
    .bank_sel_o(bank_sel_o), .group_sel_o(group_sel_o),
    .sel_type_o(sel_type_o), .lo_byte_o(lo_byte_o), .hi_byte_o(hi_byte_o),
    .dev_addr_o(dev_addr_o), .opt_mode_o(opt_mode_o),
    .local_mode_o(local_mode_o));
  bus_master_model mst (.clk_i(clk_i), .sys_req_o(sys_req_i),
    .sys_addr_o(sys_addr_i), .sys_hi_en_o(sys_hi_en_i),
    .loc_req_o(loc_req_i), .loc_addr_o(loc_addr_i),
    .loc_hi_en_o(loc_hi_en_i));
  task automatic chk(input string w, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", w, e, s);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [3:0] a);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 rd = reg_rdata_o;
  endtask : rdr
  // Drive one bus cycle and compare decode three edges later
  task automatic dec(input logic l, input logic [23:0] a, input logic h,
                     input logic [1:0] b, input logic [3:0] g,
                     input logic [1:0] ln);
    mst.drive(l, a, h);
    repeat (3) @(posedge clk_i);
    #1 chk("bank", 32'(bank_sel_o), 32'(b));
    chk("lanes", 32'({lo_byte_o, hi_byte_o}), 32'(ln));
    if (b != 2'b00) chk("group", 32'(group_sel_o), 32'(g));
  endtask : dec
  task automatic t_reset;
    logic [3:0]  ra [7] = '{REG_CTRL, REG_BANK0_MAP, REG_BANK1_MAP,
                            REG_BANK0_OFS, REG_BANK1_OFS, REG_TYPES, 4'h9};
    logic [31:0] rv [7] = '{32'h1, 32'h2, 32'h2, 32'h0, 32'h4000,
                            32'h2222, 32'h0};
    for (int i = 0; i < 7; i++) begin
      rdr(ra[i]);
      chk("reset reg", rd, rv[i]);
    end
    dec(0, 24'h080010, 1, 2'b01, 4'h1, 2'b11);
    chk("type", 32'(sel_type_o), 32'(DEV_SRAM));
    dec(0, 24'h082000, 0, 2'b01, 4'h2, 2'b10);
    dec(0, 24'h086001, 1, 2'b10, 4'h8, 2'b01);
    dec(0, 24'h088000, 1, 2'b00, 4'h0, 2'b00);
    dec(0, 24'h07fffe, 1, 2'b00, 4'h0, 2'b00);
  endtask : t_reset
  task automatic t_pages;
    wr(REG_BANK0_MAP, 32'h3f);
    wr(REG_BANK1_MAP, 32'h01);
    wr(REG_BANK1_OFS, 32'h0);
    dec(0, 24'hfc0004, 0, 2'b01, 4'h1, 2'b10);
    chk("dev addr", 32'(dev_addr_o), 32'h7e0002);
    dec(0, 24'h040000, 0, 2'b10, 4'h4, 2'b10);
    dec(0, 24'h080010, 0, 2'b00, 4'h0, 2'b00);
  endtask : t_pages
  task automatic t_down;
    wr(REG_BANK0_MAP, 32'h1201);
    wr(REG_BANK0_OFS, 32'h10000);
    dec(0, 24'h060000, 0, 2'b01, 4'h1, 2'b10);
    dec(0, 24'h06ffff, 1, 2'b01, 4'h2, 2'b01);
    dec(0, 24'h05ffff, 1, 2'b00, 4'h0, 2'b00);
    dec(0, 24'h070000, 0, 2'b00, 4'h0, 2'b00);
  endtask : t_down
  task automatic t_types;
    wr(REG_TYPES, 32'h2410);
    dec(0, 24'h068000, 0, 2'b01, 4'h2, 2'b10);
    chk("type", 32'(sel_type_o), 32'(DEV_EEPROM));
    dec(0, 24'h040000, 0, 2'b10, 4'h4, 2'b10);
    chk("type", 32'(sel_type_o), 32'(DEV_NVRAM));
    wr(REG_TYPES, 32'h2415);
    rdr(REG_TYPES);
    chk("types kept", rd, 32'h2410);
    rdr(REG_STATUS);
    chk("type reject", 32'(rd[5]), 32'h1);
  endtask : t_types
  task automatic t_modes;
    wr(REG_CTRL, 32'h0);
    dec(0, 24'h040001, 1, 2'b10, 4'h4, 2'b01);
    dec(0, 24'h040000, 1, 2'b10, 4'h4, 2'b10);
    wr(REG_CTRL, 32'h7);
    rdr(REG_CTRL);
    chk("ctrl", rd, 32'h7);
    chk("local", 32'(local_mode_o), 32'h1);
    dec(0, 24'h040000, 0, 2'b00, 4'h0, 2'b00);
    dec(1, 24'h040002, 1, 2'b10, 4'h4, 2'b11);
    chk("opt", 32'(opt_mode_o), 32'h1);
    wr(REG_CTRL, 32'h3);
    dec(1, 24'h040002, 1, 2'b10, 4'h4, 2'b11);
    chk("opt", 32'(opt_mode_o), 32'h0);
    wr(REG_BANK0_MAP, 32'h0201);
    wr(REG_BANK0_OFS, 32'h38000);
    dec(1, 24'h07c000, 1, 2'b00, 4'h0, 2'b00);
    rdr(REG_STATUS);
    chk("overflow", 32'(rd[4:3]), 32'h1);
  endtask : t_modes
  task automatic conclude;
    if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    resetn_i = 1'b0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 32'h0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_reset();
    t_pages();
    t_down();
    t_types();
    t_modes();
    conclude();
  end
  initial begin
    #100000;
    err_total++;
    conclude();
  end
endmodule : tb_paged_memory_board_decoder
